// ---- irio_host.sv ----
// Host side of the byte I/O window: single-byte read and write cycles.
// Assumes strobes are taken on the rising clk edge, one byte per access.
`timescale 1ns/1ps

module irio_host (
  input wire logic clk, // System clock
  output logic [2:0] io_addr, // Byte offset
  output logic io_wr, // Write strobe
  output logic io_rd, // Read strobe
  output logic [7:0] io_wdata, // Write byte
  input wire logic [7:0] io_rdata, // Read byte
  input wire logic io_rvalid // Read byte valid
);
  initial begin
    io_addr = 3'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // One whole byte per access, never read and write together
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1 io_wr = 1'b0;
    io_wdata = ~d;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    int n;
    @(posedge clk);
    #1 io_addr = a;
    io_rd = 1'b1;
    @(posedge clk);
    #1 io_rd = 1'b0;
    n = 0;
    while (io_rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1 n++;
    end
    // A missing answer must never look like data
    d = (n < 4) ? io_rdata : 8'hxx;
  endtask
endmodule

// ---- irio_pkg.sv ----
// Constants for the isolated relay and input port block.
// Assumes a byte-wide host I/O bus that decodes an eight-byte window.
package irio_pkg;

  localparam int unsigned IRIO_DATA_W = 8;
  localparam int unsigned IRIO_ADDR_W = 3;
  localparam int unsigned IRIO_CHANS = 8;
  localparam int unsigned IRIO_PORTS = 2;

  // Byte offsets inside the decoded window
  localparam logic [2:0] IRIO_A_RELAY_OFS = 3'h0;
  localparam logic [2:0] IRIO_A_INPUT_OFS = 3'h1;
  localparam logic [2:0] IRIO_A_FILT_OFS = 3'h2;
  localparam logic [2:0] IRIO_A_UNUSED_OFS = 3'h3;
  localparam logic [2:0] IRIO_B_RELAY_OFS = 3'h4;
  localparam logic [2:0] IRIO_B_INPUT_OFS = 3'h5;
  localparam logic [2:0] IRIO_B_FILT_OFS = 3'h6;
  localparam logic [2:0] IRIO_B_UNUSED_OFS = 3'h7;

  // Reset values: relays released, filters off
  localparam logic [7:0] IRIO_RELAY_RST = 8'h00;
  localparam logic [7:0] IRIO_FILT_RST = 8'h00;
  // Reads of write-only or unused offsets
  localparam logic [7:0] IRIO_READ_ZERO = 8'h00;

  // Input filter time constant
  localparam int unsigned IRIO_CLK_PERIOD_NS = 8;
  localparam int unsigned IRIO_FILT_TIME_US = 5000;
  localparam int unsigned IRIO_FILT_CYCLES =
    (IRIO_FILT_TIME_US * 1000) / IRIO_CLK_PERIOD_NS;
  localparam int unsigned IRIO_FILT_CNT_W = 20;

endpackage

// ---- irio_ports.sv ----
// Two independent eight-channel relay output and isolated input ports
// behind eight byte addresses of a host I/O bus.
// Assumes the host presents one byte access at a time, each as a
// one-cycle read or write strobe in the clk domain, never both at once.
//
// What this block does
// - Port A relay register decodes at offset 0 and port B at offset 4.
// - A written relay byte drives eight relays, a 1 energising a relay.
// - Reading a relay register returns the held byte, 1 meaning energised.
// - Energised means common to normally open, else normally closed.
// - Input registers sit at offsets 1 and 5 and ignore writes.
// - Reading an input register gives one bit per input, 1 for voltage.
// - Each input has its own switchable low-pass filter of about 5 ms.
// - Each port has a write-only filter select register, port A at 2.
// - Ports A and B work independently on own addresses and pins.
// - The block claims eight addresses of which two are unused.
// - Register bit n maps to channel n of its port.
// - Every access is a single byte, each bit one channel.
// - Input and relay readback use the same weight layout, 2**n.
// - A filter select bit of 1 enables that filter, 0 disables it.
// - After reset every input filter is disabled.
`timescale 1ns/1ps

module irio_ports #(
  parameter int unsigned FILT_CYCLES = irio_pkg::IRIO_FILT_CYCLES
) (
  input wire logic clk, // 125 MHz system clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [irio_pkg::IRIO_ADDR_W-1:0] io_addr, // Byte offset
  input wire logic io_wr, // Write strobe, one cycle
  input wire logic io_rd, // Read strobe, one cycle
  input wire logic [irio_pkg::IRIO_DATA_W-1:0] io_wdata, // Write byte
  output logic [irio_pkg::IRIO_DATA_W-1:0] io_rdata, // Read byte
  output logic io_rvalid, // Read byte valid, one cycle
  output logic [irio_pkg::IRIO_CHANS-1:0] relay_out_a, // Port A relays
  output logic [irio_pkg::IRIO_CHANS-1:0] relay_out_b, // Port B relays
  input wire logic [irio_pkg::IRIO_CHANS-1:0] iso_in_a, // Port A inputs
  input wire logic [irio_pkg::IRIO_CHANS-1:0] iso_in_b // Port B inputs
);
  import irio_pkg::*;

  localparam int unsigned NCH = IRIO_CHANS * IRIO_PORTS;
  localparam logic [IRIO_FILT_CNT_W-1:0] FILT_LAST =
    IRIO_FILT_CNT_W'(FILT_CYCLES - 1);

  logic [7:0] relay_a_reg;
  logic [7:0] relay_b_reg;
  logic [7:0] filt_a_reg;
  logic [7:0] filt_b_reg;
  logic [NCH-1:0] sync1_reg;
  logic [NCH-1:0] sync2_reg;
  logic [NCH-1:0] settled_reg;
  logic [NCH-1:0] settled_next;
  logic [IRIO_FILT_CNT_W-1:0] cnt_reg [NCH];
  logic [IRIO_FILT_CNT_W-1:0] cnt_next [NCH];
  logic [NCH-1:0] cnt_done;
  logic [7:0] rdata_reg;
  logic rvalid_reg;

  // Address decode
  wire wr_relay_a = io_wr && (io_addr == IRIO_A_RELAY_OFS);
  wire wr_relay_b = io_wr && (io_addr == IRIO_B_RELAY_OFS);
  wire wr_filt_a = io_wr && (io_addr == IRIO_A_FILT_OFS);
  wire wr_filt_b = io_wr && (io_addr == IRIO_B_FILT_OFS);

  // Per-channel view: raw synced level, or filtered level when enabled
  wire [NCH-1:0] filt_en = {filt_b_reg, filt_a_reg};
  wire [NCH-1:0] in_view = (filt_en & settled_reg) |
                           (~filt_en & sync2_reg);
  wire [7:0] in_view_a = in_view[7:0];
  wire [7:0] in_view_b = in_view[15:8];

  // Read selection; write-only and unused offsets read as zero
  wire [7:0] rd_mux =
    (io_addr == IRIO_A_RELAY_OFS) ? relay_a_reg :
    (io_addr == IRIO_A_INPUT_OFS) ? in_view_a :
    (io_addr == IRIO_B_RELAY_OFS) ? relay_b_reg :
    (io_addr == IRIO_B_INPUT_OFS) ? in_view_b :
    IRIO_READ_ZERO;

  // Relay drive: a set bit energises the coil, pulling common onto the
  // normally open contact; a clear bit lets it fall back to closed.
  assign relay_out_a = relay_a_reg;
  assign relay_out_b = relay_b_reg;
  assign io_rdata = rdata_reg;
  assign io_rvalid = rvalid_reg;

  // Relay registers; writes to input offsets touch nothing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      relay_a_reg <= IRIO_RELAY_RST;
      relay_b_reg <= IRIO_RELAY_RST;
    end else begin
      if (wr_relay_a) relay_a_reg <= io_wdata;
      if (wr_relay_b) relay_b_reg <= io_wdata;
    end
  end

  // Filter select registers, write-only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      filt_a_reg <= IRIO_FILT_RST;
      filt_b_reg <= IRIO_FILT_RST;
    end else begin
      if (wr_filt_a) filt_a_reg <= io_wdata;
      if (wr_filt_b) filt_b_reg <= io_wdata;
    end
  end

  // Isolated inputs come from optocouplers, so two flops first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {iso_in_b, iso_in_a};
      sync2_reg <= sync1_reg;
    end
  end

  // Filter: a channel's settled level follows the input only after the
  // input has differed from it for the whole time constant. Runs even when
  // disabled so that enabling a filter never shows a stale level for long.
  always_comb begin
    settled_next = settled_reg;
    for (int i = 0; i < NCH; i++) begin
      cnt_done[i] = (cnt_reg[i] == FILT_LAST);
      if (sync2_reg[i] == settled_reg[i]) begin
        cnt_next[i] = '0;
      end else if (cnt_done[i]) begin
        cnt_next[i] = '0;
        settled_next[i] = sync2_reg[i];
      end else begin
        cnt_next[i] = cnt_reg[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settled_reg <= '0;
      for (int i = 0; i < NCH; i++) cnt_reg[i] <= '0;
    end else begin
      settled_reg <= settled_next;
      for (int i = 0; i < NCH; i++) cnt_reg[i] <= cnt_next[i];
    end
  end

  // Read data registered; answer one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= IRIO_READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= io_rd;
      if (io_rd) rdata_reg <= rd_mux;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_relay_a_write: assert property (
    wr_relay_a |=> relay_out_a == $past(io_wdata))
    else $error("port A relay write not applied");

  a_relay_b_write: assert property (
    wr_relay_b |=> relay_out_b == $past(io_wdata))
    else $error("port B relay write not applied at offset 4");

  a_relay_readback: assert property (
    io_rd && !io_wr && io_addr == IRIO_A_RELAY_OFS
      |=> io_rvalid && io_rdata == relay_out_a)
    else $error("relay readback differs from drive");

  a_input_ro: assert property (
    io_wr && (io_addr == IRIO_A_INPUT_OFS || io_addr == IRIO_B_INPUT_OFS)
      |=> $stable(relay_out_a) && $stable(relay_out_b) &&
          $stable(filt_en))
    else $error("write to input register changed state");

  a_input_read: assert property (
    io_rd && io_addr == IRIO_B_INPUT_OFS
      |=> io_rdata == $past(in_view_b))
    else $error("port B input read wrong");

  a_filter_change: assert property (
    settled_reg != $past(settled_reg) |-> $past(|cnt_done))
    else $error("filtered level moved before time constant");

  a_filter_write: assert property (
    wr_filt_a |=> filt_a_reg == $past(io_wdata))
    else $error("port A filter select not stored");

  a_unused_read: assert property (
    io_rd && (io_addr == IRIO_A_UNUSED_OFS || io_addr == IRIO_B_FILT_OFS)
      |=> io_rdata == IRIO_READ_ZERO)
    else $error("unused or write-only offset read nonzero");

  a_port_indep: assert property (
    io_wr && !io_addr[2] |=> $stable(relay_out_b) && $stable(filt_b_reg))
    else $error("port A write disturbed port B");

  a_rvalid_cause: assert property (
    io_rvalid |-> $past(io_rd))
    else $error("read answer without strobe");

  a_raw_when_off: assert property (
    !filt_a_reg[0] |-> in_view_a[0] == sync2_reg[0])
    else $error("disabled filter still applied");

  a_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
    !arst_n |-> relay_out_a == 8'h00 && relay_out_b == 8'h00 &&
      filt_en == 16'h0000)
    else $error("reset left relays or filters on");

  // Holding behaviour: registers move only on their own strobe
  a_relay_a_hold: assert property (
    !wr_relay_a |=> $stable(relay_out_a))
    else $error("port A relays moved without a write");

  a_relay_b_hold: assert property (
    !wr_relay_b |=> $stable(relay_out_b))
    else $error("port B relays moved without a write");

  a_filt_b_write: assert property (
    wr_filt_b |=> filt_b_reg == $past(io_wdata))
    else $error("port B filter select not stored");

  a_filt_hold: assert property (
    !wr_filt_a && !wr_filt_b |=> $stable(filt_en))
    else $error("filter select moved without a write");

  a_relay_b_readback: assert property (
    io_rd && !io_wr && io_addr == IRIO_B_RELAY_OFS
      |=> io_rvalid && io_rdata == relay_out_b)
    else $error("port B relay readback differs from drive");

  a_input_a_read: assert property (
    io_rd && io_addr == IRIO_A_INPUT_OFS
      |=> io_rdata == $past(in_view_a))
    else $error("port A input read wrong");

  a_wo_read: assert property (
    io_rd && (io_addr == IRIO_A_FILT_OFS || io_addr == IRIO_B_UNUSED_OFS)
      |=> io_rdata == IRIO_READ_ZERO)
    else $error("write-only or unused offset read nonzero");

  a_rvalid_pulse: assert property (
    io_rd |=> io_rvalid)
    else $error("read strobe got no answer");

  a_rvalid_quiet: assert property (
    !io_rd |=> !io_rvalid)
    else $error("read answer lasted more than one cycle");

  a_rdata_hold: assert property (
    !io_rd |=> $stable(io_rdata))
    else $error("read byte changed without a read");

  // Filter timer on channel 0 stands for all sixteen channels
  a_filter_hold: assert property (
    !cnt_done[0] |=> settled_reg[0] == $past(settled_reg[0]))
    else $error("filtered level moved before timer expired");

  a_filter_restart: assert property (
    sync2_reg[0] == settled_reg[0] |=> cnt_reg[0] == '0)
    else $error("filter timer not restarted on agreement");

  a_cnt_bound: assert property (
    cnt_reg[0] <= FILT_LAST)
    else $error("filter timer ran past its end");

  a_raw_b_off: assert property (
    !filt_b_reg[7] |-> in_view_b[7] == sync2_reg[15])
    else $error("disabled port B filter still applied");

  a_filtered_view: assert property (
    filt_a_reg[0] |-> in_view_a[0] == settled_reg[0])
    else $error("enabled filter not applied");

  a_filtered_b: assert property (
    filt_b_reg[0] |-> in_view_b[0] == settled_reg[8])
    else $error("enabled port B filter not applied");

  a_port_b_indep: assert property (
    io_wr && io_addr[2] |=> $stable(relay_out_a) && $stable(filt_a_reg))
    else $error("port B write disturbed port A");

  a_relay_msb: assert property (
    wr_relay_a |=> relay_out_a[7] == $past(io_wdata[7]))
    else $error("bit 7 not mapped to relay 7");

  a_relay_lsb: assert property (
    wr_relay_b |=> relay_out_b[0] == $past(io_wdata[0]))
    else $error("bit 0 not mapped to relay 0");

  a_bit_weight: assert property (
    io_rd && io_addr == IRIO_A_INPUT_OFS
      |=> io_rdata[0] == $past(in_view[0]))
    else $error("input bit weight wrong");

  a_sync_follow: assert property (
    sync2_reg == $past(sync1_reg))
    else $error("input synchroniser skipped a stage");

  // Reset must also drop any settled level, so no filter starts stale
  a_reset_filt: assert property (@(posedge clk) disable iff (1'b0)
    !arst_n |-> settled_reg == '0 && filt_en == 16'h0000)
    else $error("reset left filter state behind");

  c_relay_write: cover property (wr_relay_b ##1 io_rd);
  c_input_read: cover property (io_rd && io_addr == IRIO_A_INPUT_OFS);
  c_filtered: cover property (
    filt_a_reg[0] && settled_next[0] != settled_reg[0]);
  c_unused: cover property (io_rd && io_addr == IRIO_B_UNUSED_OFS);
  c_back_to_back: cover property (wr_relay_a ##1 wr_relay_b);

endmodule

// ---- tb_top.sv ----
// Self-checking bench for the relay and isolated input ports.
// Assumes a short filter time so settling fits in a brief run.
`timescale 1ns/1ps

module tb_top;
  import irio_pkg::*;
  localparam int unsigned FC = 16;
  logic clk = 1'b0;
  logic arst_n;
  logic [2:0] io_addr;
  logic io_wr, io_rd, io_rvalid;
  logic [7:0] io_wdata, io_rdata, relay_out_a, relay_out_b;
  logic [7:0] iso_in_a = 8'h00;
  logic [7:0] iso_in_b = 8'h00;
  logic [7:0] d;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  irio_ports #(.FILT_CYCLES(FC)) irio_ports_i (.clk(clk), .arst_n(arst_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .relay_out_a(relay_out_a),
    .relay_out_b(relay_out_b), .iso_in_a(iso_in_a), .iso_in_b(iso_in_b));

  irio_host irio_host_i (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic results();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic t_reset();
    chk("relay_out_a", IRIO_RELAY_RST, relay_out_a);
    chk("relay_out_b", IRIO_RELAY_RST, relay_out_b);
    irio_host_i.rd(IRIO_A_RELAY_OFS, d);
    chk("relay a read", 8'h00, d);
    $display("test reset done");
  endtask

  task automatic t_relay();
    irio_host_i.wr(IRIO_A_RELAY_OFS, 8'hab);
    irio_host_i.wr(IRIO_B_RELAY_OFS, 8'h54);
    chk("relay_out_a", 8'hab, relay_out_a);
    chk("relay_out_b", 8'h54, relay_out_b);
    // Writes to input and unused offsets must leave the relays alone
    for (int a = 1; a < 8; a += 2) begin
      irio_host_i.wr(3'(a), 8'hff);
    end
    chk("relay_out_a kept", 8'hab, relay_out_a);
    chk("relay_out_b kept", 8'h54, relay_out_b);
    irio_host_i.rd(IRIO_A_RELAY_OFS, d);
    chk("relay a read", 8'hab, d);
    irio_host_i.rd(IRIO_B_RELAY_OFS, d);
    chk("relay b read", 8'h54, d);
    foreach (relay_out_a[n]) begin
      chk("relay bit", 8'(n == 0 || n % 2 == 1), 8'(relay_out_a[n]));
    end
    $display("test relay done");
  endtask

  task automatic t_inputs();
    @(posedge clk);
    #1 iso_in_a = 8'h81;
    iso_in_b = 8'h3c;
    repeat (3) @(posedge clk);
    irio_host_i.rd(IRIO_A_INPUT_OFS, d);
    chk("input a", 8'h81, d);
    irio_host_i.rd(IRIO_B_INPUT_OFS, d);
    chk("input b", 8'h3c, d);
    foreach (d[i]) begin
      irio_host_i.rd(3'(i), d);
      if (i[1:0] > 1) chk("unused read", IRIO_READ_ZERO, d);
    end
    $display("test inputs done");
  endtask

  task automatic t_filter();
    irio_host_i.wr(IRIO_A_FILT_OFS, 8'h01);
    @(posedge clk);
    #1 iso_in_a = 8'h80;
    iso_in_b = 8'h3d;
    repeat (FC / 2) @(posedge clk);
    #1 iso_in_a = 8'h81;
    irio_host_i.rd(IRIO_A_INPUT_OFS, d);
    chk("short pulse", 8'h81, d);
    irio_host_i.rd(IRIO_B_INPUT_OFS, d);
    chk("b unfiltered", 8'h3d, d);
    #1 iso_in_a = 8'h00;
    repeat (FC + 8) @(posedge clk);
    irio_host_i.rd(IRIO_A_INPUT_OFS, d);
    chk("settled", 8'h00, d);
    irio_host_i.wr(IRIO_A_FILT_OFS, 8'h00);
    @(posedge clk);
    #1 iso_in_a = 8'h01;
    repeat (3) @(posedge clk);
    irio_host_i.rd(IRIO_A_INPUT_OFS, d);
    chk("filter off", 8'h01, d);
    $display("test filter done");
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    // Driven at time zero so the reset edge reaches the design
    arst_n = 1'b0;
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    t_reset();
    t_relay();
    t_inputs();
    t_filter();
    results();
  end
endmodule
